// *** dv/scr_config_bank_tb_top.sv ***
// testbench: reset words, read/write, field outputs and bus errors of the config bank
`timescale 1ns/1ps
module scr_config_bank_tb_top;
  import scr_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0000_0000;
  logic [31:0] wbDatR;
  logic wbAck;
  logic wbErr;
  logic [2:0] oscCoreSelect;
  logic oscCoreForce;
  logic [2:0] activeCoreHint;
  logic firstHalvingEnable;
  logic [18:0] feedbackDivider;
  logic [5:0] detectorDelaySelect;
  int err_count = 0;
  int checks = 0;
  int cycleCount = 0;
  logic [15:0] resetTable [18] = '{16'h3048, 16'h0401, 16'h0001, 16'h007c, 16'h071a, 16'h0624,
    16'h0db0, 16'h0002, 16'h0488, 16'h318c, 16'h318c, 16'hc3ec, 16'h0393, 16'h1e21, 16'h0010,
    16'h0004, 16'h0070, 16'h0205};
  // values software loads: reserved fields at their required settings
  logic [15:0] progTable [18] = '{16'hf048, 16'h0401, 16'h0001, 16'h007c, 16'h071a, 16'h0624,
    16'h0db0, 16'h0002, 16'h0488, 16'h318c, 16'h318c, 16'h43ec, 16'h0393, 16'h1e21, 16'h0000,
    16'h0004, 16'h0070, 16'h0205};
  logic [31:0] rdVal;
  logic gotErr;

  scr_config_bank dut_u (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .wb_err_o(wbErr), .oscCoreSelect(oscCoreSelect),
    .oscCoreForce(oscCoreForce), .activeCoreHint(activeCoreHint),
    .firstHalvingEnable(firstHalvingEnable), .feedbackDivider(feedbackDivider),
    .detectorDelaySelect(detectorDelaySelect));

  always #2.5 clk = ~clk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // the whole run needs about 400 cycles; a hang is cut off well beyond that
  always @(posedge clk)
  begin
    cycleCount++;
    if (cycleCount == 6000)
    begin
      err_count++;
      $display("wrong value at %0t: run timed out", $time);
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] adrOf(input int i);
    return 8'(8'h50 + 4 * i);
  endfunction

  // one classic cycle; request held until ack or err is sampled high
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
    input logic [31:0] wdata, output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatW <= wdata;
    do
    begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 50);
    rdata = wbDatR;
    err = wbErr;
    if (n >= 50)
    begin
      err_count++;
      $display("wrong value at %0t: no bus answer", $time);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [15:0] d);
    wbXfer(1'b1, adr, 4'b0011, {16'h0000, d}, rdVal, gotErr);
    check({31'h0, gotErr}, 32'h0, "write answered with error");
  endtask

  task automatic rdChk(input logic [7:0] adr, input logic [15:0] exp, input string what);
    wbXfer(1'b0, adr, 4'b0011, 32'h0000_0000, rdVal, gotErr);
    check({31'h0, gotErr}, 32'h0, "read answered with error");
    check(rdVal, {16'h0000, exp}, what);
  endtask

  // field outputs settle one edge after the word; sample after that edge
  task automatic fieldsChk(input logic [2:0] sel, input logic frc, input logic [2:0] hint,
    input logic halv, input logic [18:0] div, input logic [5:0] dly);
    @(posedge clk);
    #1;
    check({29'h0, oscCoreSelect}, {29'h0, sel}, "core select");
    check({31'h0, oscCoreForce}, {31'h0, frc}, "core force");
    check({29'h0, activeCoreHint}, {29'h0, hint}, "forced core");
    check({31'h0, firstHalvingEnable}, {31'h0, halv}, "halving enable");
    check({13'h0, feedbackDivider}, {13'h0, div}, "feedback divider");
    check({26'h0, detectorDelaySelect}, {26'h0, dly}, "delay select");
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    fieldsChk(3'h6, 1'b0, 3'h0, 1'b1, 19'h0_0070, 6'h02);
    for (int i = 0; i < 18; i++)
      rdChk(adrOf(i), resetTable[i], "reset word");
    for (int i = 0; i < 18; i++)
      wr(adrOf(i), ~resetTable[i]);
    for (int i = 0; i < 18; i++)
      rdChk(adrOf(i), ~resetTable[i], "inverted word");
    fieldsChk(3'h1, 1'b1, 3'h1, 1'b0, 19'h7_ff8f, 6'h3d);
    for (int c = 1; c < 8; c++)
    begin
      wr(8'h50, 16'hc448 | 16'(c << 11));
      fieldsChk(3'(c), 1'b1, 3'(c), 1'b0, 19'h7_ff8f, 6'h3d);
      wr(8'h50, 16'hc048 | 16'(c << 11));
      fieldsChk(3'(c), 1'b0, 3'h0, 1'b0, 19'h7_ff8f, 6'h3d);
    end
    // byte lanes: only the selected half of the low divider word changes
    wbXfer(1'b1, 8'h90, 4'b0001, 32'h0000_1234, rdVal, gotErr);
    wbXfer(1'b1, 8'h90, 4'b0010, 32'h0000_5600, rdVal, gotErr);
    rdChk(8'h90, 16'h5634, "lane write");
    wr(8'h88, 16'h0005);
    fieldsChk(3'h7, 1'b0, 3'h0, 1'b0, 19'h5_5634, 6'h3d);
    wbXfer(1'b1, 8'h4c, 4'b0011, 32'h0000_0000, rdVal, gotErr);
    check({31'h0, gotErr}, 32'h1, "below range");
    wbXfer(1'b0, 8'h98, 4'b0011, 32'h0000_0000, rdVal, gotErr);
    check({31'h0, gotErr}, 32'h1, "above range");
    wbXfer(1'b1, 8'h51, 4'b0011, 32'h0000_0000, rdVal, gotErr);
    check({31'h0, gotErr}, 32'h1, "misaligned");
    rdChk(8'h50, 16'hc048 | 16'h3800, "untouched after error");
    for (int i = 0; i < 18; i++)
      wr(adrOf(i), progTable[i]);
    for (int i = 0; i < 18; i++)
      rdChk(adrOf(i), progTable[i], "programmed word");
    fieldsChk(3'h6, 1'b0, 3'h0, 1'b1, 19'h0_0070, 6'h02);
    // second reset in mid-run brings the words back
    wr(8'h7c, 16'h0000);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdChk(8'h7c, 16'hc3ec, "word after second reset");
    final_report();
  end
endmodule

// *** hdl/scr_config_bank.sv ***
// top: wishbone slave holding the synthesizer configuration words
`timescale 1ns/1ps
// Operation
// - core select field bits 13:11 of 0x14 resets to 6, names start core
// - force bit 10 of 0x14 makes device use selected core; resets 0
// - bit 14 of 0x1F enables first channel halving stage; resets 1
// - divider is 19 bits; upper three in 0x22 bits 2:0, reset 0
// - lower sixteen divider bits fill 0x24, reset 0x70
// - delay select bits 13:8 of 0x25 resets to 2, chosen by software
module scr_config_bank
  import scr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic [2:0] oscCoreSelect,
  output logic oscCoreForce,
  output logic [2:0] activeCoreHint,
  output logic firstHalvingEnable,
  output logic [18:0] feedbackDivider,
  output logic [5:0] detectorDelaySelect
);
  function automatic logic indexHit(input logic [5:0] idx);
    indexHit = (idx >= 6'(SCR_FIRST_IDX)) && (idx <= 6'(SCR_LAST_IDX));
  endfunction

  function automatic logic [4:0] slotOf(input logic [5:0] idx);
    logic [5:0] diff;
    diff = idx - 6'(SCR_FIRST_IDX);
    slotOf = diff[4:0];
  endfunction

  scr_bus_state_t busState_reg;
  scr_bus_state_t busState_next;
  logic [15:0] regValue [SCR_NUM_REGS];
  logic [SCR_NUM_REGS-1:0] wordWrite;
  logic [5:0] reqIndex;
  logic reqAligned;
  logic reqHit;
  logic reqNew;
  logic [15:0] readWord;
  logic [31:0] wbDat_next;

  // byte address is four times the index; low two bits must be zero
  assign reqIndex = wb_adr_i[7:2];
  assign reqAligned = (wb_adr_i[1:0] == 2'b00);
  assign reqHit = reqAligned && indexHit(reqIndex);
  assign reqNew = wb_cyc_i && wb_stb_i && (busState_reg == SCR_IDLE);

  always_comb
  begin
    busState_next = busState_reg;
    case (busState_reg)
      SCR_IDLE:
        if (reqNew)
          busState_next = SCR_ACK;
      SCR_ACK:
        busState_next = SCR_IDLE;
      default:
        busState_next = SCR_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      busState_reg <= SCR_IDLE;
    else
      busState_reg <= busState_next;
  end

  // answer one cycle after the request; ack for mapped words, err otherwise
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= reqNew && reqHit;
      wb_err_o <= reqNew && !reqHit;
    end
  end

  // write strobe per word, taken in the request cycle
  genvar g;
  generate
    for (g = 0; g < SCR_NUM_REGS; g++)
    begin : gen_words
      assign wordWrite[g] = reqNew && reqHit && wb_we_i &&
        (slotOf(reqIndex) == 5'(g));
      scr_word_reg #(
        .RESET_VALUE(SCR_RESET_VECTOR[g*16 +: 16])
      ) u_word (
        .clk(clk),
        .reset_n(reset_n),
        .writeEn(wordWrite[g]),
        .laneSel(wb_sel_i[1:0]),
        .writeData(wb_dat_i[15:0]),
        .value(regValue[g])
      );
    end
  endgenerate

  always_comb
  begin
    readWord = 16'h0000;
    if (reqHit)
      readWord = regValue[slotOf(reqIndex)];
    wbDat_next = {16'h0000, readWord};
  end

  // read data captured with the ack; upper half reads zero
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      wb_dat_o <= 32'h0000_0000;
    else if (reqNew && !wb_we_i)
      wb_dat_o <= wbDat_next;
  end

  // field outputs track the words one cycle later, all from flip-flops
  logic [15:0] coreWord;
  logic [15:0] divStageWord;
  logic [15:0] fbHighWord;
  logic [15:0] fbLowWord;
  logic [15:0] delayWord;
  assign coreWord = regValue[slotOf(CORE_SELECT_CTRL_IDX)];
  assign divStageWord = regValue[slotOf(DIVIDER_STAGE_CTRL_IDX)];
  assign fbHighWord = regValue[slotOf(FEEDBACK_DIV_HIGH_IDX)];
  assign fbLowWord = regValue[slotOf(FEEDBACK_DIV_LOW_IDX)];
  assign delayWord = regValue[slotOf(DETECTOR_DELAY_CTRL_IDX)];

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      oscCoreSelect <= OSC_CORE_SELECT_RST;
    else
      oscCoreSelect <= coreWord[OSC_CORE_SELECT_LSB +: OSC_CORE_SELECT_W];
  end

  // core force and the core in use when forced
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      oscCoreForce <= OSC_CORE_FORCE_RST[0];
      activeCoreHint <= 3'h0;
    end
    else
    begin
      oscCoreForce <= coreWord[OSC_CORE_FORCE_BIT];
      // zero means no forced core; calibration picks freely
      activeCoreHint <= coreWord[OSC_CORE_FORCE_BIT] ?
        coreWord[OSC_CORE_SELECT_LSB +: OSC_CORE_SELECT_W] : 3'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      firstHalvingEnable <= FIRST_HALVING_ENABLE_RST[0];
    else
      firstHalvingEnable <= divStageWord[FIRST_HALVING_ENABLE_BIT];
  end

  // assemble the 19-bit divider; halves may change apart
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      feedbackDivider <= {FEEDBACK_DIV_HIGH_RST[FB_DIV_HIGH_LSB +: FB_DIV_HIGH_W],
        FEEDBACK_DIV_LOW_RST};
    else
      feedbackDivider <= {fbHighWord[FB_DIV_HIGH_LSB +: FB_DIV_HIGH_W], fbLowWord};
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      detectorDelaySelect <= DETECTOR_DELAY_SELECT_RST;
    else
      detectorDelaySelect <= delayWord[DETECTOR_DELAY_SELECT_LSB +: DETECTOR_DELAY_SELECT_W];
  end

  a_core_sel_follow: assert property (@(posedge clk) disable iff (!reset_n)
    wordWrite[0] && wb_sel_i[1] ##2 1'b1 |->
    oscCoreSelect == $past(wb_dat_i[13:11], 2))
    else $error("core select does not follow write");

  a_core_force_use: assert property (@(posedge clk) disable iff (!reset_n)
    oscCoreForce |-> activeCoreHint == oscCoreSelect)
    else $error("forced core not in use");

  a_core_force_off: assert property (@(posedge clk) disable iff (!reset_n)
    !oscCoreForce |-> activeCoreHint == 3'h0)
    else $error("core hint set while force off");

  a_halving_follow: assert property (@(posedge clk) disable iff (!reset_n)
    wordWrite[11] && wb_sel_i[1] |-> ##2 firstHalvingEnable == $past(wb_dat_i[14], 2))
    else $error("halving enable does not follow write");

  a_div_high: assert property (@(posedge clk) disable iff (!reset_n)
    wordWrite[14] && wb_sel_i[0] |-> ##2 feedbackDivider[18:16] == $past(wb_dat_i[2:0], 2))
    else $error("divider high bits wrong");

  a_div_low: assert property (@(posedge clk) disable iff (!reset_n)
    wordWrite[16] && (wb_sel_i[1:0] == 2'b11) |->
    ##2 feedbackDivider[15:0] == $past(wb_dat_i[15:0], 2))
    else $error("divider low bits wrong");

  a_delay_follow: assert property (@(posedge clk) disable iff (!reset_n)
    wordWrite[17] && wb_sel_i[1] |-> ##2 detectorDelaySelect == $past(wb_dat_i[13:8], 2))
    else $error("delay select does not follow write");

  // reads return the stored word, one cycle ack
  a_read_back: assert property (@(posedge clk) disable iff (!reset_n)
    reqNew && reqHit && !wb_we_i |=> wb_ack_o && wb_dat_o[15:0] == $past(readWord)
    ##1 !wb_ack_o)
    else $error("read answer wrong");

  // unmapped access gets err, never ack
  a_unmapped_err: assert property (@(posedge clk) disable iff (!reset_n)
    reqNew && !reqHit |=> wb_err_o && !wb_ack_o && wb_dat_o[31:16] == 16'h0000)
    else $error("unmapped access answered wrong");
endmodule

// *** hdl/scr_word_reg.sv ***
// one sixteen-bit read/write register word with reset value and byte lanes
`timescale 1ns/1ps
module scr_word_reg
  import scr_pkg::*;
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic writeEn,
  input wire logic [1:0] laneSel,
  input wire logic [15:0] writeData,
  output logic [15:0] value
);
  logic [15:0] wordReg;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      wordReg <= RESET_VALUE;
    else if (writeEn)
    begin
      if (laneSel[0])
        wordReg[7:0] <= writeData[7:0];
      if (laneSel[1])
        wordReg[15:8] <= writeData[15:8];
    end
  end

  assign value = wordReg;

  a_word_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !writeEn |=> value == $past(value))
    else $error("word changed without write");
endmodule

// *** include/scr_pkg.sv ***
// package: register map, field layout and reset values of the synthesizer config bank
package scr_pkg;
  localparam int SCR_DATA_W = 16;
  localparam int SCR_IDX_W = 6;
  localparam int SCR_FIRST_IDX = 6'h14;
  localparam int SCR_LAST_IDX = 6'h25;
  localparam int SCR_NUM_REGS = SCR_LAST_IDX - SCR_FIRST_IDX + 1;

  // register indices; byte address is four times the index
  localparam logic [5:0] CORE_SELECT_CTRL_IDX = 6'h14;
  localparam logic [5:0] FIXED_WORD_A_IDX = 6'h15;
  localparam logic [5:0] FIXED_WORD_B_IDX = 6'h16;
  localparam logic [5:0] FIXED_WORD_C_IDX = 6'h17;
  localparam logic [5:0] FIXED_WORD_D_IDX = 6'h18;
  localparam logic [5:0] FIXED_WORD_E_IDX = 6'h19;
  localparam logic [5:0] FIXED_WORD_F_IDX = 6'h1a;
  localparam logic [5:0] FIXED_WORD_G_IDX = 6'h1b;
  localparam logic [5:0] FIXED_WORD_H_IDX = 6'h1c;
  localparam logic [5:0] FIXED_WORD_I_IDX = 6'h1d;
  localparam logic [5:0] FIXED_WORD_J_IDX = 6'h1e;
  localparam logic [5:0] DIVIDER_STAGE_CTRL_IDX = 6'h1f;
  localparam logic [5:0] FIXED_WORD_K_IDX = 6'h20;
  localparam logic [5:0] FIXED_WORD_L_IDX = 6'h21;
  localparam logic [5:0] FEEDBACK_DIV_HIGH_IDX = 6'h22;
  localparam logic [5:0] FIXED_WORD_M_IDX = 6'h23;
  localparam logic [5:0] FEEDBACK_DIV_LOW_IDX = 6'h24;
  localparam logic [5:0] DETECTOR_DELAY_CTRL_IDX = 6'h25;

  // reset values, in index order
  localparam logic [15:0] CORE_SELECT_CTRL_RST = 16'h3048;
  localparam logic [15:0] FIXED_WORD_A_RST = 16'h0401;
  localparam logic [15:0] FIXED_WORD_B_RST = 16'h0001;
  localparam logic [15:0] FIXED_WORD_C_RST = 16'h007c;
  localparam logic [15:0] FIXED_WORD_D_RST = 16'h071a;
  localparam logic [15:0] FIXED_WORD_E_RST = 16'h0624;
  localparam logic [15:0] FIXED_WORD_F_RST = 16'h0db0;
  localparam logic [15:0] FIXED_WORD_G_RST = 16'h0002;
  localparam logic [15:0] FIXED_WORD_H_RST = 16'h0488;
  localparam logic [15:0] FIXED_WORD_I_RST = 16'h318c;
  localparam logic [15:0] FIXED_WORD_J_RST = 16'h318c;
  localparam logic [15:0] DIVIDER_STAGE_CTRL_RST = 16'hc3ec;
  localparam logic [15:0] FIXED_WORD_K_RST = 16'h0393;
  localparam logic [15:0] FIXED_WORD_L_RST = 16'h1e21;
  localparam logic [15:0] FEEDBACK_DIV_HIGH_RST = 16'h0010;
  localparam logic [15:0] FIXED_WORD_M_RST = 16'h0004;
  localparam logic [15:0] FEEDBACK_DIV_LOW_RST = 16'h0070;
  localparam logic [15:0] DETECTOR_DELAY_CTRL_RST = 16'h0205;

  // field positions
  localparam int OSC_CORE_SELECT_LSB = 11;
  localparam int OSC_CORE_SELECT_W = 3;
  localparam int OSC_CORE_FORCE_BIT = 10;
  localparam int FIRST_HALVING_ENABLE_BIT = 14;
  localparam int FB_DIV_HIGH_LSB = 0;
  localparam int FB_DIV_HIGH_W = 3;
  localparam int FB_DIV_W = 19;
  localparam int DETECTOR_DELAY_SELECT_LSB = 8;
  localparam int DETECTOR_DELAY_SELECT_W = 6;

  // field reset values
  localparam logic [2:0] OSC_CORE_SELECT_RST = 3'h6;
  localparam logic [0:0] OSC_CORE_FORCE_RST = 1'h0;
  localparam logic [0:0] FIRST_HALVING_ENABLE_RST = 1'h1;
  localparam logic [5:0] DETECTOR_DELAY_SELECT_RST = 6'h02;

  localparam logic [SCR_NUM_REGS*16-1:0] SCR_RESET_VECTOR = {
    DETECTOR_DELAY_CTRL_RST, FEEDBACK_DIV_LOW_RST, FIXED_WORD_M_RST,
    FEEDBACK_DIV_HIGH_RST, FIXED_WORD_L_RST, FIXED_WORD_K_RST,
    DIVIDER_STAGE_CTRL_RST, FIXED_WORD_J_RST, FIXED_WORD_I_RST,
    FIXED_WORD_H_RST, FIXED_WORD_G_RST, FIXED_WORD_F_RST,
    FIXED_WORD_E_RST, FIXED_WORD_D_RST, FIXED_WORD_C_RST,
    FIXED_WORD_B_RST, FIXED_WORD_A_RST, CORE_SELECT_CTRL_RST};

  typedef enum logic [1:0] {
    SCR_IDLE = 2'b01,
    SCR_ACK = 2'b10
  } scr_bus_state_t;
endpackage
